// >>> hw/alert_ctl.sv
// Purpose: Alert pin control with trip flags, polarity, style and shutdown
// Assumes: TEMP and CONV_DONE come from the converter on the MCLK domain
// Notes:   Zero-wait APB slave while CE is high; the alert pin is open-drain, low when driven
//
// Behaviour
// - Polarity 0 active low, 1 active high
// - Polarity write ignored while any lock set
// - Polarity change moves pin at once
// - Shutdown freezes or de-asserts pin per setting
// - Other settings apply after post-shutdown conversion
// - Some bus settings defer polarity during shutdown
// - Style 0 comparator, 1 latched interrupt
// - Style write ignored while any lock set
// - Window flags set and clear with hysteresis
// - Critical flag sets at threshold, hysteretic clear
// - Output enable 0 keeps pin inactive
// - Critical-only mode alerts on critical only

`timescale 1ns/1ps
`default_nettype none

module alert_ctl
#(
	parameter int TW = alert_ctl_pkg::TEMP_W
)
(
	// Clock, reset and enable
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Converter side
	input wire logic [TW-1:0] TEMP,
	input wire logic CONV_DONE,
	// Open-drain alert pin
	output logic EVENT_O,
	output logic EVENT_OE
);

	// Software-written settings
	logic style_r, style_nxt;
	logic pol_r, pol_nxt;
	logic crit_only_r, crit_only_nxt;
	logic alert_on_r, alert_on_nxt;
	logic shdn_r, shdn_nxt;
	logic crit_lock_r, crit_lock_nxt;
	logic win_lock_r, win_lock_nxt;
	logic sleep_lvl_r, sleep_lvl_nxt;
	logic tmo_off_r, tmo_off_nxt;
	logic sdio_r, sdio_nxt;
	logic [TW-1:0] upper_r, upper_nxt;
	logic [TW-1:0] lower_r, lower_nxt;
	logic [TW-1:0] crit_r, crit_nxt;
	logic [TW-1:0] hyst_r, hyst_nxt;

	// Settings in effect
	logic eff_style_r, eff_style_nxt;
	logic eff_pol_r, eff_pol_nxt;
	logic eff_crit_only_r, eff_crit_only_nxt;
	logic eff_alert_on_r, eff_alert_on_nxt;
	logic eff_sleep_lvl_r, eff_sleep_lvl_nxt;
	logic eff_tmo_off_r, eff_tmo_off_nxt;
	logic eff_sdio_r, eff_sdio_nxt;
	logic pend_r, pend_nxt; // Waiting for a conversion after wake

	// Alert path state
	logic cond_q_r, cond_q_nxt; // Condition as last seen
	logic latch_r, latch_nxt; // Interrupt-style event latch
	logic asserted_r, asserted_nxt; // Logical alert state
	logic level_r, level_nxt; // Pin level wanted

	// Bus answer registers
	logic [31:0] rdata_r, rdata_nxt;
	logic err_r, err_nxt;

	// Decode and helpers
	logic wr, setup, any_lock, cfg_wr, bus_wr, hit, hold_cfg, defer_pol;
	logic conv, cond, active, below, above, crit_f, clr_evt;
	logic signed [TW:0] t_x, up_x, lo_x, cr_x, hy_x;

	assign wr = PSEL & PENABLE & PWRITE;
	assign setup = PSEL & ~PENABLE;
	assign any_lock = crit_lock_r | win_lock_r;
	assign cfg_wr = wr && PADDR == alert_ctl_pkg::OFS_CONFIG;
	assign bus_wr = wr && PADDR == alert_ctl_pkg::OFS_BUSCTL;
	assign clr_evt = cfg_wr && PWDATA[alert_ctl_pkg::CFG_CLR_EVENT];
	assign hold_cfg = shdn_r | pend_r;
	assign defer_pol = shdn_r & (eff_tmo_off_r | ~eff_sdio_r);
	assign conv = CONV_DONE & ~shdn_r;

	// Sign-extend one bit so threshold minus a hysteresis up to 4096 cannot wrap
	assign t_x = {TEMP[TW-1], TEMP};
	assign up_x = {upper_r[TW-1], upper_r};
	assign lo_x = {lower_r[TW-1], lower_r};
	assign cr_x = {crit_r[TW-1], crit_r};
	assign hy_x = {1'b0, hyst_r};

	// Address hit for the answer
	always_comb
	begin
		unique case (PADDR)
			alert_ctl_pkg::OFS_CONFIG, alert_ctl_pkg::OFS_BUSCTL,
			alert_ctl_pkg::OFS_UPPER, alert_ctl_pkg::OFS_LOWER,
			alert_ctl_pkg::OFS_CRIT, alert_ctl_pkg::OFS_HYST,
			alert_ctl_pkg::OFS_STATUS:
				hit = 1'b1;
			default:
				hit = 1'b0;
		endcase
	end

	// Software settings: lock protection on polarity, style and enables
	always_comb
	begin
		style_nxt = style_r;
		pol_nxt = pol_r;
		crit_only_nxt = crit_only_r;
		alert_on_nxt = alert_on_r;
		shdn_nxt = shdn_r;
		crit_lock_nxt = crit_lock_r;
		win_lock_nxt = win_lock_r;
		sleep_lvl_nxt = sleep_lvl_r;
		tmo_off_nxt = tmo_off_r;
		sdio_nxt = sdio_r;
		upper_nxt = upper_r;
		lower_nxt = lower_r;
		crit_nxt = crit_r;
		hyst_nxt = hyst_r;
		if (cfg_wr)
		begin
			if (!any_lock)
			begin
				pol_nxt = PWDATA[alert_ctl_pkg::CFG_POL];
				style_nxt = PWDATA[alert_ctl_pkg::CFG_STYLE];
				alert_on_nxt = PWDATA[alert_ctl_pkg::CFG_ALERT_ON];
			end
			// Critical-only is guarded by the window lock alone
			if (!win_lock_r)
				crit_only_nxt = PWDATA[alert_ctl_pkg::CFG_CRIT_ONLY];
			shdn_nxt = PWDATA[alert_ctl_pkg::CFG_SHUTDOWN];
			crit_lock_nxt = PWDATA[alert_ctl_pkg::CFG_CRIT_LOCK];
			win_lock_nxt = PWDATA[alert_ctl_pkg::CFG_WIN_LOCK];
		end
		if (bus_wr)
		begin
			sleep_lvl_nxt = PWDATA[alert_ctl_pkg::BUS_SLEEP_LVL];
			tmo_off_nxt = PWDATA[alert_ctl_pkg::BUS_TMO_OFF];
			sdio_nxt = PWDATA[alert_ctl_pkg::BUS_SDIO_EN];
		end
		if (wr && PADDR == alert_ctl_pkg::OFS_UPPER)
			upper_nxt = PWDATA[TW-1:0];
		if (wr && PADDR == alert_ctl_pkg::OFS_LOWER)
			lower_nxt = PWDATA[TW-1:0];
		if (wr && PADDR == alert_ctl_pkg::OFS_CRIT)
			crit_nxt = PWDATA[TW-1:0];
		if (wr && PADDR == alert_ctl_pkg::OFS_HYST)
			hyst_nxt = PWDATA[TW-1:0];
	end

	// Settings register
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			style_r <= alert_ctl_pkg::CFG_BIT_RESET;
			pol_r <= alert_ctl_pkg::CFG_BIT_RESET;
			crit_only_r <= alert_ctl_pkg::CFG_BIT_RESET;
			alert_on_r <= alert_ctl_pkg::CFG_BIT_RESET;
			shdn_r <= alert_ctl_pkg::CFG_BIT_RESET;
			crit_lock_r <= alert_ctl_pkg::CFG_BIT_RESET;
			win_lock_r <= alert_ctl_pkg::CFG_BIT_RESET;
			sleep_lvl_r <= alert_ctl_pkg::CFG_BIT_RESET;
			tmo_off_r <= alert_ctl_pkg::CFG_BIT_RESET;
			sdio_r <= alert_ctl_pkg::CFG_BIT_RESET;
			upper_r <= alert_ctl_pkg::THRESH_RESET;
			lower_r <= alert_ctl_pkg::THRESH_RESET;
			crit_r <= alert_ctl_pkg::THRESH_RESET;
			hyst_r <= alert_ctl_pkg::THRESH_RESET;
		end
		else if (CE)
		begin
			style_r <= style_nxt;
			pol_r <= pol_nxt;
			crit_only_r <= crit_only_nxt;
			alert_on_r <= alert_on_nxt;
			shdn_r <= shdn_nxt;
			crit_lock_r <= crit_lock_nxt;
			win_lock_r <= win_lock_nxt;
			sleep_lvl_r <= sleep_lvl_nxt;
			tmo_off_r <= tmo_off_nxt;
			sdio_r <= sdio_nxt;
			upper_r <= upper_nxt;
			lower_r <= lower_nxt;
			crit_r <= crit_nxt;
			hyst_r <= hyst_nxt;
		end
	end

	// Effective settings: all but polarity frozen in shutdown and until the first wake conversion
	always_comb
	begin
		eff_style_nxt = eff_style_r;
		eff_crit_only_nxt = eff_crit_only_r;
		eff_alert_on_nxt = eff_alert_on_r;
		eff_sleep_lvl_nxt = eff_sleep_lvl_r;
		eff_tmo_off_nxt = eff_tmo_off_r;
		eff_sdio_nxt = eff_sdio_r;
		pend_nxt = pend_r;
		// Wake arms the wait; a real conversion ends it
		if (shdn_r && !shdn_nxt)
			pend_nxt = 1'b1;
		else if (pend_r && conv)
			pend_nxt = 1'b0;
		if (!hold_cfg)
		begin
			eff_style_nxt = style_r;
			eff_crit_only_nxt = crit_only_r;
			eff_alert_on_nxt = alert_on_r;
			eff_sleep_lvl_nxt = sleep_lvl_r;
			eff_tmo_off_nxt = tmo_off_r;
			eff_sdio_nxt = sdio_r;
		end
		// Polarity bypasses the wake wait; the bus options can defer it only in shutdown
		eff_pol_nxt = defer_pol ? eff_pol_r : pol_r;
	end

	// Effective settings register
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			eff_style_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_pol_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_crit_only_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_alert_on_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_sleep_lvl_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_tmo_off_r <= alert_ctl_pkg::CFG_BIT_RESET;
			eff_sdio_r <= alert_ctl_pkg::CFG_BIT_RESET;
			pend_r <= 1'b0;
		end
		else if (CE)
		begin
			eff_style_r <= eff_style_nxt;
			eff_pol_r <= eff_pol_nxt;
			eff_crit_only_r <= eff_crit_only_nxt;
			eff_alert_on_r <= eff_alert_on_nxt;
			eff_sleep_lvl_r <= eff_sleep_lvl_nxt;
			eff_tmo_off_r <= eff_tmo_off_nxt;
			eff_sdio_r <= eff_sdio_nxt;
			pend_r <= pend_nxt;
		end
	end

	// Below window: set under lower minus hysteresis, clear at lower
	hyst_flag u_below
	(
		.clk(MCLK),
		.reset(RESET),
		.ce(CE),
		.update(conv),
		.set_cond(t_x < lo_x - hy_x),
		.clr_cond(t_x >= lo_x),
		.flag(below)
	);

	// Above window: set over upper, clear under upper minus hysteresis
	hyst_flag u_above
	(
		.clk(MCLK),
		.reset(RESET),
		.ce(CE),
		.update(conv),
		.set_cond(t_x > up_x),
		.clr_cond(t_x < up_x - hy_x),
		.flag(above)
	);

	// Critical: set at threshold, clear under threshold minus hysteresis
	hyst_flag u_crit
	(
		.clk(MCLK),
		.reset(RESET),
		.ce(CE),
		.update(conv),
		.set_cond(t_x >= cr_x),
		.clr_cond(t_x < cr_x - hy_x),
		.flag(crit_f)
	);

	// Alert condition chosen by critical-only mode
	assign cond = eff_crit_only_r ? crit_f : (crit_f | above | below);
	assign active = eff_alert_on_r & (eff_style_r ? latch_r : cond);

	// Alert path: latch on a new condition, freeze or release in shutdown
	always_comb
	begin
		cond_q_nxt = cond;
		// New event wins over a clear in the same cycle
		latch_nxt = (cond & ~cond_q_r) | (latch_r & ~clr_evt);
		if (shdn_r)
			asserted_nxt = eff_sleep_lvl_r ? 1'b0 : asserted_r;
		else
			asserted_nxt = active;
		// Pin level: asserted equals polarity, idle is its inverse
		level_nxt = asserted_nxt ? eff_pol_nxt : ~eff_pol_nxt;
	end

	// Alert path register
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			cond_q_r <= 1'b0;
			latch_r <= 1'b0;
			asserted_r <= 1'b0;
			level_r <= alert_ctl_pkg::PIN_LEVEL_RESET;
		end
		else if (CE)
		begin
			cond_q_r <= cond_q_nxt;
			latch_r <= latch_nxt;
			asserted_r <= asserted_nxt;
			level_r <= level_nxt;
		end
	end

	// Open-drain pin: pull low for a low level, release for high
	assign EVENT_O = 1'b0;
	assign EVENT_OE = ~level_r;

	// Read data captured in the setup cycle, shown in the access cycle
	always_comb
	begin
		rdata_nxt = rdata_r;
		err_nxt = err_r;
		if (setup)
		begin
			rdata_nxt = 32'h0000_0000;
			err_nxt = ~hit;
			unique case (PADDR)
				alert_ctl_pkg::OFS_CONFIG:
					rdata_nxt[7:0] = {win_lock_r, crit_lock_r, 1'b0, shdn_r,
						alert_on_r, crit_only_r, pol_r, style_r};
				alert_ctl_pkg::OFS_BUSCTL:
					rdata_nxt[2:0] = {sdio_r, tmo_off_r, sleep_lvl_r};
				alert_ctl_pkg::OFS_UPPER:
					rdata_nxt[TW-1:0] = upper_r;
				alert_ctl_pkg::OFS_LOWER:
					rdata_nxt[TW-1:0] = lower_r;
				alert_ctl_pkg::OFS_CRIT:
					rdata_nxt[TW-1:0] = crit_r;
				alert_ctl_pkg::OFS_HYST:
					rdata_nxt[TW-1:0] = hyst_r;
				alert_ctl_pkg::OFS_STATUS:
				begin
					rdata_nxt[alert_ctl_pkg::ST_BELOW] = below;
					rdata_nxt[alert_ctl_pkg::ST_ABOVE] = above;
					rdata_nxt[alert_ctl_pkg::ST_CRIT] = crit_f;
					rdata_nxt[alert_ctl_pkg::ST_LATCH] = latch_r;
					rdata_nxt[alert_ctl_pkg::ST_ASSERTED] = asserted_r;
					rdata_nxt[alert_ctl_pkg::ST_PENDING] = pend_r;
					rdata_nxt[alert_ctl_pkg::ST_EFF_POL] = eff_pol_r;
				end
				default:
					rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Bus answer register
	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			rdata_r <= 32'h0000_0000;
			err_r <= 1'b0;
		end
		else if (CE)
		begin
			rdata_r <= rdata_nxt;
			err_r <= err_nxt;
		end
	end

	assign PRDATA = rdata_r;
	assign PREADY = CE;
	assign PSLVERR = PSEL & PENABLE & err_r;

	// Active-low asserted pin is driven low
	chk_pol_level: assert property (@(posedge MCLK) disable iff (RESET)
		CE && asserted_nxt && !eff_pol_nxt |=> EVENT_OE)
		else $error("alert not driven low in active-low mode");

	chk_pol_lock: assert property (@(posedge MCLK) disable iff (RESET)
		CE && cfg_wr && any_lock |=> $stable(pol_r))
		else $error("polarity changed while locked");

	chk_pol_now: assert property (@(posedge MCLK) disable iff (RESET)
		CE && !defer_pol && pol_r != eff_pol_r |=> eff_pol_r == $past(pol_r))
		else $error("polarity not applied at once");

	chk_sleep_off: assert property (@(posedge MCLK) disable iff (RESET)
		CE && shdn_r && eff_sleep_lvl_r |=> !asserted_r)
		else $error("alert asserted in de-asserting shutdown");

	chk_sleep_freeze: assert property (@(posedge MCLK) disable iff (RESET)
		shdn_r && !eff_sleep_lvl_r |=> $stable(asserted_r))
		else $error("alert moved in freezing shutdown");

	chk_cfg_hold: assert property (@(posedge MCLK) disable iff (RESET)
		hold_cfg |=> $stable(eff_style_r) && $stable(eff_alert_on_r))
		else $error("setting applied before wake conversion");

	chk_pol_defer: assert property (@(posedge MCLK) disable iff (RESET)
		defer_pol |=> $stable(eff_pol_r))
		else $error("polarity applied while deferred");

	chk_cmp_follow: assert property (@(posedge MCLK) disable iff (RESET)
		CE && !shdn_r && eff_alert_on_r && !eff_style_r && cond |=> asserted_r)
		else $error("comparator output missed condition");

	chk_style_lock: assert property (@(posedge MCLK) disable iff (RESET)
		CE && cfg_wr && any_lock |=> $stable(style_r))
		else $error("style changed while locked");

	chk_above_set: assert property (@(posedge MCLK) disable iff (RESET)
		CE && conv && t_x > up_x |=> above)
		else $error("above flag not set");

	chk_crit_set: assert property (@(posedge MCLK) disable iff (RESET)
		CE && conv && t_x >= cr_x |=> crit_f)
		else $error("critical flag not set");

	chk_out_off: assert property (@(posedge MCLK) disable iff (RESET)
		CE && !shdn_r && !eff_alert_on_r |=> !asserted_r)
		else $error("alert asserted while output off");

	chk_crit_only: assert property (@(posedge MCLK) disable iff (RESET)
		CE && !shdn_r && eff_crit_only_r && !eff_style_r && !crit_f |=> !asserted_r)
		else $error("alert asserted without critical in critical-only mode");

endmodule

`default_nettype wire

// >>> hw/alert_ctl_pkg.sv
// Purpose: Shared constants for the temperature alert output control block
// Assumes: APB byte addresses, 32-bit data, one register per aligned word
// Notes:   Temperatures are two's complement, 0.125 degC per LSB

`default_nettype none

package alert_ctl_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_BUSCTL = 8'h04;
	localparam logic [7:0] OFS_UPPER = 8'h08;
	localparam logic [7:0] OFS_LOWER = 8'h0c;
	localparam logic [7:0] OFS_CRIT = 8'h10;
	localparam logic [7:0] OFS_HYST = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// Configuration register fields
	localparam int CFG_STYLE = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_CRIT_ONLY = 2;
	localparam int CFG_ALERT_ON = 3;
	localparam int CFG_SHUTDOWN = 4;
	localparam int CFG_CLR_EVENT = 5;
	localparam int CFG_CRIT_LOCK = 6;
	localparam int CFG_WIN_LOCK = 7;

	// Bus-level control register fields
	localparam int BUS_SLEEP_LVL = 0;
	localparam int BUS_TMO_OFF = 1;
	localparam int BUS_SDIO_EN = 2;

	// Status register fields
	localparam int ST_BELOW = 0;
	localparam int ST_ABOVE = 1;
	localparam int ST_CRIT = 2;
	localparam int ST_LATCH = 3;
	localparam int ST_ASSERTED = 4;
	localparam int ST_PENDING = 5;
	localparam int ST_EFF_POL = 6;

	// Width of temperature and threshold words
	localparam int TEMP_W = 13;

	// Values after reset
	localparam logic CFG_BIT_RESET = 1'b0;
	localparam logic [12:0] THRESH_RESET = 13'h0000;
	localparam logic PIN_LEVEL_RESET = 1'b1;

endpackage

`default_nettype wire

// >>> hw/hyst_flag.sv
// Purpose: One trip-status flag with separate set and clear thresholds
// Assumes: Conditions are valid in the cycle that update is high
// Notes:   Set has priority if both conditions are true together

`timescale 1ns/1ps
`default_nettype none

module hyst_flag
(
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Evaluation
	input wire logic update,
	input wire logic set_cond,
	input wire logic clr_cond,
	// Result
	output logic flag
);

	logic flag_r; // Stored trip state
	logic flag_nxt; // Next trip state

	// Hysteresis: only a crossing of the far threshold changes the state
	always_comb
	begin
		flag_nxt = flag_r;
		if (update && set_cond)
			flag_nxt = 1'b1;
		else if (update && clr_cond)
			flag_nxt = 1'b0;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
			flag_r <= 1'b0;
		else if (ce)
			flag_r <= flag_nxt;
	end

	assign flag = flag_r;

endmodule

`default_nettype wire

// >>> verif/alert_host.sv
// Purpose: Host-side view of the open-drain alert line
// Assumes: The board holds the line high with a pull-up resistor
// Notes:   The host only listens; it never drives the line

`timescale 1ns/1ps
`default_nettype none

module alert_host
(
	// Pin from the block
	input wire logic pin_o,
	input wire logic pin_oe,
	// Level the host input sees
	output logic level
);
	// Pull-up wins whenever the block lets go of the line
	assign level = pin_oe ? pin_o : 1'b1;
endmodule

`default_nettype wire

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the alert output control block
// Assumes: CE high apart from one frozen stretch, so APB accesses need no waits
// Notes:   Trip flags are modelled here and compared through STATUS

`timescale 1ns/1ps
`default_nettype none

module testbench;
	// Config bit masks
	localparam logic [31:0] sty_b = 32'h1 << alert_ctl_pkg::CFG_STYLE;
	localparam logic [31:0] pol_b = 32'h1 << alert_ctl_pkg::CFG_POL;
	localparam logic [31:0] co_b = 32'h1 << alert_ctl_pkg::CFG_CRIT_ONLY;
	localparam logic [31:0] on_b = 32'h1 << alert_ctl_pkg::CFG_ALERT_ON;
	localparam logic [31:0] sd_b = 32'h1 << alert_ctl_pkg::CFG_SHUTDOWN;
	localparam logic [31:0] clr_b = 32'h1 << alert_ctl_pkg::CFG_CLR_EVENT;
	localparam logic [31:0] lkc_b = 32'h1 << alert_ctl_pkg::CFG_CRIT_LOCK;
	localparam logic [31:0] lkw_b = 32'h1 << alert_ctl_pkg::CFG_WIN_LOCK;
	// Thresholds in 0.125 degC units
	localparam int up_t = 256;
	localparam int lo_t = 128;
	localparam int cr_t = 512;
	localparam int hy_t = 16;
	localparam logic [12:0] hot = 13'h0180;
	localparam logic [12:0] cool = 13'h00c0;
	localparam logic [7:0] cfg_a = alert_ctl_pkg::OFS_CONFIG;
	localparam logic [7:0] bus_a = alert_ctl_pkg::OFS_BUSCTL;
	// Design-side signals
	logic mclk, rst, psel, penable, pwrite, cdone, lvl, ev_o, ev_oe, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, cfgs, seed;
	logic [12:0] temp, t;
	logic e, fb, fa, fc, ce;
	int errors, total_checks, i;
	// Boundary temperatures around every set and clear point
	logic [12:0] cn [11] = '{13'h080, 13'h06f, 13'h070, 13'h080, 13'h100, 13'h101,
		13'h0f0, 13'h0ef, 13'h200, 13'h1f0, 13'h1ef};

	alert_ctl DUT (.MCLK(mclk), .RESET(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .TEMP(temp), .CONV_DONE(cdone),
		.EVENT_O(ev_o), .EVENT_OE(ev_oe));
	alert_host host (.pin_o(ev_o), .pin_oe(ev_oe), .level(lvl));

	// Free-running 10 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Verdict and end of run
	task close_out;
		if (errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Value comparison
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Xorshift source, seeded with 84
	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Flag with separate set and clear points; set wins
	function automatic logic hyst(input logic f, input logic s, input logic c);
		return s ? 1'b1 : (c ? 1'b0 : f);
	endfunction

	// Expected line level from alert state and polarity
	function automatic logic epin(input logic a, input logic p);
		return p ? a : ~a;
	endfunction

	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
		begin
			errors++;
			close_out();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (w && a == cfg_a)
			cfgs = d;
	endtask

	// Temperature conversion pulse; model skips it in shutdown
	task conv(input logic [12:0] tv);
		int ti;
		@(posedge mclk);
		temp <= tv;
		cdone <= 1'b1;
		@(posedge mclk);
		cdone <= 1'b0;
		ti = int'($signed(tv));
		if (!cfgs[alert_ctl_pkg::CFG_SHUTDOWN])
		begin
			fb = hyst(fb, ti < lo_t - hy_t, ti >= lo_t);
			fa = hyst(fa, ti > up_t, ti < up_t - hy_t);
			fc = hyst(fc, ti >= cr_t, ti < cr_t - hy_t);
		end
		repeat (2) @(posedge mclk);
	endtask

	// Line level once the output has settled
	task pin(input logic ex);
		repeat (3) @(posedge mclk);
		chk("alert line", {31'h0, ex}, {31'h0, lvl});
	endtask

	// Main sequence
	initial
	begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		temp = 13'h0000;
		cdone = 1'b0;
		cfgs = 32'h0;
		seed = 32'd84;
		{fb, fa, fc} = 3'b000;
		errors = 0;
		total_checks = 0;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		// Every register clears on reset; line idles high
		for (i = 0; i < 7; i++)
		begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("reset value", 32'h0, q);
		end
		pin(1'b1);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		// Clock enable low freezes the flags through a conversion pulse
		@(posedge mclk);
		ce <= 1'b0;
		temp <= hot;
		cdone <= 1'b1;
		@(posedge mclk);
		cdone <= 1'b0;
		@(posedge mclk);
		ce <= 1'b1;
		apb(1'b0, alert_ctl_pkg::OFS_STATUS, 32'h0);
		chk("frozen flags", {29'h0, fc, fa, fb}, q & 32'h7);
		// Thresholds, then comparator mode with output on
		apb(1'b1, alert_ctl_pkg::OFS_UPPER, 32'(up_t));
		apb(1'b1, alert_ctl_pkg::OFS_LOWER, 32'(lo_t));
		apb(1'b1, alert_ctl_pkg::OFS_CRIT, 32'(cr_t));
		apb(1'b1, alert_ctl_pkg::OFS_HYST, 32'(hy_t));
		apb(1'b1, cfg_a, on_b);
		// Corner temperatures first, then random ones
		for (i = 0; i < 40; i++)
		begin
			if (i == 25)
				apb(1'b1, cfg_a, on_b | co_b);
			seed = xs(seed);
			t = (i < 11) ? cn[i] : 13'h060 + 13'(seed % 32'h1c0);
			conv(t);
			apb(1'b0, alert_ctl_pkg::OFS_STATUS, 32'h0);
			chk("trip flags", {29'h0, fc, fa, fb}, q & 32'h7);
			pin(epin(i >= 25 ? fc : (fa | fb | fc), 1'b0));
		end
		// Polarity flip moves the line at once
		apb(1'b1, cfg_a, on_b);
		conv(hot);
		pin(1'b0);
		apb(1'b1, cfg_a, on_b | pol_b);
		pin(1'b1);
		// Either lock blocks polarity and style writes
		apb(1'b1, cfg_a, on_b | pol_b | lkc_b);
		apb(1'b1, cfg_a, on_b | sty_b | lkc_b);
		apb(1'b0, cfg_a, 32'h0);
		chk("config crit lock", on_b | pol_b | lkc_b, q);
		apb(1'b1, cfg_a, on_b | pol_b | lkw_b);
		apb(1'b1, cfg_a, on_b | sty_b | lkw_b);
		apb(1'b0, cfg_a, 32'h0);
		chk("config window lock", on_b | pol_b | lkw_b, q);
		apb(1'b1, cfg_a, on_b | pol_b);
		apb(1'b1, cfg_a, on_b | sty_b);
		apb(1'b0, cfg_a, 32'h0);
		chk("config unlocked", on_b | sty_b, q);
		// Interrupt mode latches until cleared
		conv(cool);
		apb(1'b1, cfg_a, on_b | sty_b | clr_b);
		pin(1'b1);
		conv(hot);
		pin(1'b0);
		conv(cool);
		pin(1'b0);
		apb(1'b1, cfg_a, on_b | sty_b | clr_b);
		pin(1'b1);
		apb(1'b1, cfg_a, on_b);
		conv(hot);
		pin(1'b0);
		// Shutdown freezes; polarity still acts at once
		apb(1'b1, bus_a, 32'h4);
		apb(1'b1, cfg_a, on_b | sd_b);
		conv(cool);
		pin(1'b0);
		apb(1'b1, cfg_a, on_b | sd_b | pol_b);
		pin(1'b1);
		apb(1'b1, cfg_a, on_b | pol_b);
		conv(hot);
		// Timeout off defers polarity until wake
		apb(1'b1, bus_a, 32'h2);
		apb(1'b1, cfg_a, on_b | pol_b | sd_b);
		apb(1'b1, cfg_a, on_b | sd_b);
		pin(1'b1);
		apb(1'b1, cfg_a, on_b);
		pin(1'b0);
		conv(hot);
		// De-assert level while asleep
		apb(1'b1, bus_a, 32'h1);
		apb(1'b1, cfg_a, on_b | sd_b);
		pin(1'b1);
		apb(1'b1, cfg_a, on_b);
		conv(hot);
		pin(1'b0);
		// Enable change waits for the first conversion after wake
		apb(1'b1, bus_a, 32'h0);
		apb(1'b1, cfg_a, on_b | sd_b);
		pin(1'b0);
		apb(1'b1, cfg_a, 32'h0);
		pin(1'b0);
		// Asserted and waiting for the wake conversion, polarity low
		apb(1'b0, alert_ctl_pkg::OFS_STATUS, 32'h0);
		chk("wake status", 32'h30, q & 32'h70);
		conv(hot);
		pin(1'b1);
		close_out();
	end
endmodule

`default_nettype wire
